/* File: bench/csf_testbench.sv */
// self-checking bench for the status flags and bank select block
// assumes csf_top with an avalon-mm slave, event pulses and one clock
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        errors++; \
        $display("wrong value %s expected %h seen %h", nm, e, g); \
    end \
end
module testbench;
    logic        clock;
    logic        srst;
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [1:0]  response;
    logic        sleep_exec;
    logic        clear_watchdog_instr;
    logic        watchdog_timeout;
    logic        master_clear_pin;
    logic        instr_tick;
    logic        bank_sel;
    logic        irq;
    int          errors;
    int          n_compared;
    int          cycles;
    logic [31:0] q;
    logic [1:0]  rsp;

    csf_top dut (
        .clock(clock), .srst(srst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .response(response), .sleep_exec(sleep_exec),
        .clear_watchdog_instr(clear_watchdog_instr),
        .watchdog_timeout(watchdog_timeout),
        .master_clear_pin(master_clear_pin), .instr_tick(instr_tick),
        .bank_sel(bank_sel), .irq(irq)
    );

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // cut a hang short
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            end_of_test();
        end
    end

    // one avalon transfer, held until waitrequest is sampled low at an edge
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        address <= a;
        write <= w;
        read <= ~w;
        writedata <= d;
        @(posedge clock);
        while (waitrequest !== 1'b0) begin
            @(posedge clock);
        end
        q = readdata;
        rsp = response;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h000000, d});
    endtask

    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h00000000);
    endtask

    // one-cycle pulse on the events: sleep, clear watchdog, timeout, master clear
    task automatic ev(input logic [3:0] m);
        @(posedge clock);
        {sleep_exec, clear_watchdog_instr, watchdog_timeout,
         master_clear_pin} <= m;
        @(posedge clock);
        {sleep_exec, clear_watchdog_instr, watchdog_timeout,
         master_clear_pin} <= 4'h0;
    endtask

    task automatic alu(input logic [7:0] a, input logic [7:0] b,
                       input logic [7:0] cmd);
        wr(8'h42, a);
        wr(8'h43, b);
        wr(8'h44, cmd);
        rd(8'h45);
    endtask

    task automatic t_reset();
        rd(8'h03);
        `CHK("status after reset", 32'h18, q)
        rd(8'h81);
        `CHK("option after reset", 32'hff, q)
        rd(8'h40);
        `CHK("irq status after reset", 32'h10, q)
        `CHK("irq after reset", 1'b0, irq)
    endtask

    task automatic t_events();
        ev(4'h2);
        rd(8'h03);
        `CHK("status after timeout", 32'h08, q)
        ev(4'h4);
        rd(8'h03);
        `CHK("status after clear watchdog", 32'h18, q)
        ev(4'h8);
        rd(8'h03);
        `CHK("status after sleep", 32'h10, q)
    endtask

    task automatic t_write_master_clear_pin();
        wr(8'h03, 8'h27);
        rd(8'h03);
        `CHK("status write keeps bits 4:3", 32'h37, q)
        @(negedge clock);
        `CHK("bank select high", 1'b1, bank_sel)
        ev(4'h1);
        rd(8'h83);
        `CHK("status after master clear", 32'h17, q)
        `CHK("bank select low", 1'b0, bank_sel)
    endtask

    task automatic t_irq();
        rd(8'h40);
        `CHK("irq status all events", 32'h1f, q)
        wr(8'h41, 8'h04);
        repeat (2) @(negedge clock);
        `CHK("irq unmasked", 1'b1, irq)
        wr(8'h40, 8'h04);
        repeat (2) @(negedge clock);
        `CHK("irq cleared", 1'b0, irq)
        rd(8'h40);
        `CHK("irq status after clear", 32'h1b, q)
        wr(8'h41, 8'h00);
    endtask

    task automatic t_alu();
        alu(8'h0f, 8'h01, 8'h00);
        `CHK("add result", 32'h10, q)
        rd(8'h03);
        `CHK("add flags", 32'h02, q & 32'h07)
        alu(8'hff, 8'h01, 8'h00);
        rd(8'h03);
        `CHK("add zero flags", 32'h07, q & 32'h07)
        alu(8'h10, 8'h01, 8'h01);
        `CHK("sub result", 32'h0f, q)
        rd(8'h03);
        `CHK("sub digit borrow", 32'h01, q & 32'h07)
        alu(8'h01, 8'h02, 8'h01);
        `CHK("sub wrap result", 32'hff, q)
        rd(8'h03);
        `CHK("sub borrow flags", 32'h00, q & 32'h07)
        alu(8'h01, 8'h00, 8'h03);
        `CHK("rotate right result", 32'h00, q)
        rd(8'h03);
        `CHK("rotate right carry", 32'h01, q & 32'h01)
        alu(8'h80, 8'h00, 8'h04);
        `CHK("rotate left result", 32'h01, q)
        rd(8'h03);
        `CHK("rotate left carry", 32'h01, q & 32'h01)
        alu(8'hf0, 8'h30, 8'h08);
        rd(8'h03);
        `CHK("flag result wins on status", 32'h31, q)
        @(negedge clock);
        `CHK("bank select from result", 1'b1, bank_sel)
    endtask

    task automatic t_timer();
        wr(8'h81, 8'h08);
        wr(8'h47, 8'h00);
        @(posedge clock);
        instr_tick <= 1'b1;
        repeat (5) @(posedge clock);
        instr_tick <= 1'b0;
        rd(8'h47);
        `CHK("timer at 1:1", 32'h05, q)
        wr(8'h81, 8'h00);
        wr(8'h47, 8'h00);
        @(posedge clock);
        instr_tick <= 1'b1;
        repeat (4) @(posedge clock);
        instr_tick <= 1'b0;
        rd(8'h47);
        `CHK("timer at 1:2", 32'h02, q)
    endtask

    task automatic t_unmapped();
        rd(8'h10);
        `CHK("unmapped read data", 32'h0, q)
        `CHK("unmapped read response", 2'b11, rsp)
        wr(8'h10, 8'h5a);
        `CHK("unmapped write response", 2'b11, rsp)
        rd(8'h03);
        `CHK("ok response", 2'b00, rsp)
        byteenable <= 4'he;
        wr(8'h42, 8'h77);
        byteenable <= 4'hf;
        rd(8'h42);
        `CHK("write without lane 0 ignored", 32'hf0, q)
    endtask

    initial begin
        errors = 0;
        n_compared = 0;
        cycles = 0;
        srst = 1'b1;
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'hf;
        sleep_exec = 1'b0;
        clear_watchdog_instr = 1'b0;
        watchdog_timeout = 1'b0;
        master_clear_pin = 1'b0;
        instr_tick = 1'b0;
        repeat (10) @(posedge clock);
        srst <= 1'b0;
        t_reset();
        t_events();
        t_write_master_clear_pin();
        t_irq();
        t_alu();
        t_timer();
        t_unmapped();
        end_of_test();
    end
endmodule

/* File: logic/csf_alu.sv */
// alu flag generator for the status flags block
// assumes operands held stable by the caller; purely combinational
`timescale 1ns/1ps
module csf_alu (
    input  wire logic [7:0]      a,
    input  wire logic [7:0]      b,
    input  wire csf_pkg::csf_op_e op,
    input  wire logic            c_in,
    output logic      [7:0]      res,
    output logic                 c_out,
    output logic                 digit_c_out,
    output logic                 z_out,
    output logic                 c_upd,
    output logic                 digit_c_upd
);
    logic [7:0] b_eff;
    logic [8:0] sum;
    logic [4:0] nib;
    // subtract adds two's complement, so carry means no borrow
    assign b_eff = (op == csf_pkg::CSF_OP_SUB) ? (~b + 8'h01) : b;
    assign sum   = {1'b0, a} + {1'b0, b_eff};
    assign nib   = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]};
    always_comb begin
        res    = 8'h00;
        c_out  = c_in;
        digit_c_out = 1'b0;
        c_upd       = 1'b0;
        digit_c_upd = 1'b0;
        case (op)
            csf_pkg::CSF_OP_ADD,
            csf_pkg::CSF_OP_SUB: begin
                res    = sum[7:0];
                // zero operand subtracts with carry set (no borrow)
                c_out  = sum[8] | ((op == csf_pkg::CSF_OP_SUB) && b == 8'h00);
                digit_c_out = nib[4] | ((op == csf_pkg::CSF_OP_SUB)
                              && b[3:0] == 4'h0);
                c_upd       = 1'b1;
                digit_c_upd = 1'b1;
            end
            csf_pkg::CSF_OP_AND: res = a & b;
            csf_pkg::CSF_OP_OR:  res = a | b;
            csf_pkg::CSF_OP_XOR: res = a ^ b;
            csf_pkg::CSF_OP_RRF: begin
                res   = {c_in, a[7:1]};
                c_out = a[0];
                c_upd = 1'b1;
            end
            csf_pkg::CSF_OP_RLF: begin
                res   = {a[6:0], c_in};
                c_out = a[7];
                c_upd = 1'b1;
            end
            csf_pkg::CSF_OP_MOV: res = a;
            default: res = 8'h00;
        endcase
    end
    assign z_out = (res == 8'h00);
endmodule

/* File: logic/csf_pkg.sv */
// constants for the status flags and bank select block
// assumes a single clock domain and an avalon-mm register master
// Overview of operation
// - watchdog flag_n set by power-up, clear-watchdog or sleep; cleared on time-out
// - in subtraction carry and digit carry read as active-low borrow
// - subtraction adds two's complement of second operand; flags from that sum
// - rotates load carry with bit shifted out: low bit right, high bit left
// - prescaler assigned to watchdog leaves timer zero counting at 1:1
// - flag-updating write to status keeps flag results, drops written bits only of the flags the op updates
// - master clear reset leaves watchdog and powerdown flags unchanged
package csf_pkg;
    localparam logic [7:0] STATUS_IDX   = 8'h03;
    localparam logic [7:0] STATUS_ALIAS = 8'h83;
    localparam logic [7:0] OPTION_IDX   = 8'h81;
    localparam logic [7:0] IRQ_STAT_IDX = 8'h40;
    localparam logic [7:0] IRQ_MASK_IDX = 8'h41;
    localparam logic [7:0] ALU_A_IDX    = 8'h42;
    localparam logic [7:0] ALU_B_IDX    = 8'h43;
    localparam logic [7:0] ALU_CMD_IDX  = 8'h44;
    localparam logic [7:0] ALU_RES_IDX  = 8'h45;
    localparam logic [7:0] EVENT_IDX    = 8'h46;
    localparam logic [7:0] TMR_IDX      = 8'h47;
    localparam int C_BIT  = 0;
    localparam int DIGIT_C_BIT    = 1;
    localparam int Z_BIT          = 2;
    localparam int POWERDOWN_BIT  = 3;
    localparam int TIMEOUT_BIT    = 4;
    localparam int BANK_LO_BIT    = 5;
    localparam int BANK_HI_BIT    = 6;
    localparam int IND_BANK_BIT   = 7;
    localparam int PRE_ASSIGN_BIT = 3;
    localparam logic [7:0] STATUS_POR = 8'h18;
    localparam logic [7:0] OPTION_POR = 8'hff;
    localparam logic [2:0] EV_SLEEP   = 3'h0;
    localparam logic [2:0] EV_CLEAR_WDOG   = 3'h1;
    localparam logic [2:0] EV_TIMEOUT      = 3'h2;
    localparam logic [2:0] EV_MASTER_CLEAR = 3'h3;
    localparam logic [2:0] EV_POR     = 3'h4;
    typedef enum logic [2:0] {
        CSF_OP_ADD = 3'b000,
        CSF_OP_SUB = 3'b001,
        CSF_OP_AND = 3'b010,
        CSF_OP_RRF = 3'b011,
        CSF_OP_RLF = 3'b100,
        CSF_OP_OR  = 3'b101,
        CSF_OP_XOR = 3'b110,
        CSF_OP_MOV = 3'b111
    } csf_op_e;
endpackage

/* File: logic/csf_tmr.sv */
// timer zero counter with shared prescaler
// assumes tick is a one-cycle instruction-rate enable
`timescale 1ns/1ps
module csf_tmr #(
    parameter int PRE_W = 8
) (
    input  wire logic       clock,
    input  wire logic       srst,
    input  wire logic       tick,
    input  wire logic       prescaler_assign_bit,
    input  wire logic [2:0] ps,
    input  wire logic       load,
    input  wire logic [7:0] load_val,
    output logic      [7:0] count
);
    logic [PRE_W-1:0] pre_reg;
    logic [7:0]       count_reg;
    logic             pre_hit;
    logic             inc;
    // timer rate 1:2 shl ps when prescaler belongs to the timer
    assign pre_hit = (pre_reg[ps] == 1'b1) &&
                     ((pre_reg & ((PRE_W'(1) << ps) - PRE_W'(1))) ==
                      PRE_W'(0)) && tick;
    assign inc     = prescaler_assign_bit ? tick : pre_hit;
    always_ff @(posedge clock) begin
        if (srst) begin
            pre_reg   <= '0;
            count_reg <= 8'h00;
        end else begin
            if (tick && !prescaler_assign_bit)
                pre_reg <= pre_reg + PRE_W'(1);
            if (load)
                count_reg <= load_val;
            else if (inc)
                count_reg <= count_reg + 8'h01;
        end
    end
    assign count = count_reg;
    property p_pre_one_to_one;
        @(posedge clock) disable iff (srst)
        prescaler_assign_bit && tick && !load
        |=> count == $past(count) + 8'h01;
    endproperty
    a_pre_one_to_one: assert property (p_pre_one_to_one)
        else $error("timer not 1:1 with prescaler on watchdog");
endmodule

/* File: logic/csf_top.sv */
// status flags and bank select register with avalon-mm access
// assumes single clock, synchronous active-high reset, event pulses
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
module csf_top (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic      [1:0]  response,
    input  wire logic        sleep_exec,
    input  wire logic        clear_watchdog_instr,
    input  wire logic        watchdog_timeout,
    input  wire logic        master_clear_pin,
    input  wire logic        instr_tick,
    output logic             bank_sel,
    output logic             irq
);
    logic [7:0] status_reg, status_next;
    logic [7:0] option_reg;
    logic [7:0] a_reg, b_reg, res_reg;
    logic [2:0] op_reg;
    logic [4:0] ist_reg, imask_reg;
    logic       ack_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  resp_reg;
    logic        por_done_reg;
    logic [7:0] alu_res;
    logic       alu_c, alu_digit_c, alu_z, c_upd, digit_c_upd;
    logic [7:0] tmr_count;
    wire  req      = (read | write) & ~ack_reg;
    wire  wr       = write & ~ack_reg & byteenable[0];
    wire  hit_st   = (address == csf_pkg::STATUS_IDX) ||
                     (address == csf_pkg::STATUS_ALIAS);
    wire  wr_st    = wr && hit_st;
    wire  wr_cmd   = wr && address == csf_pkg::ALU_CMD_IDX;
    wire  wr_a     = wr && address == csf_pkg::ALU_A_IDX;
    wire  wr_b     = wr && address == csf_pkg::ALU_B_IDX;
    wire  wr_opt   = wr && address == csf_pkg::OPTION_IDX;
    wire  wr_ist   = wr && address == csf_pkg::IRQ_STAT_IDX;
    wire  wr_imk   = wr && address == csf_pkg::IRQ_MASK_IDX;
    wire  wr_tmr   = wr && address == csf_pkg::TMR_IDX;
    wire  cmd_st   = wr_cmd && writedata[3];
    wire  por_ev   = !por_done_reg;
    wire  mapped   = hit_st || address == csf_pkg::OPTION_IDX ||
                     (address >= csf_pkg::IRQ_STAT_IDX &&
                      address <= csf_pkg::TMR_IDX);
    wire [4:0] ev_vec = {por_ev, master_clear_pin, watchdog_timeout,
                         clear_watchdog_instr, sleep_exec};

    csf_alu u_alu (
        .a           (a_reg),
        .b           (b_reg),
        .op          (csf_pkg::csf_op_e'(writedata[2:0])),
        .c_in        (status_reg[csf_pkg::C_BIT]),
        .res         (alu_res),
        .c_out       (alu_c),
        .digit_c_out (alu_digit_c),
        .z_out       (alu_z),
        .c_upd       (c_upd),
        .digit_c_upd (digit_c_upd)
    );

    csf_tmr u_tmr (
        .clock    (clock),
        .srst     (srst),
        .tick     (instr_tick),
        .prescaler_assign_bit (option_reg[csf_pkg::PRE_ASSIGN_BIT]),
        .ps       (option_reg[2:0]),
        .load     (wr_tmr),
        .load_val (writedata[7:0]),
        .count    (tmr_count)
    );

    // status next value: bus write, then alu flags, then events
    always_comb begin
        status_next = status_reg;
        if (wr_st) begin
            status_next[7:5] = writedata[7:5];
            status_next[2:0] = writedata[2:0];
        end
        if (wr_cmd) begin
            if (cmd_st) begin
                // flag results override written value of z, and of c and dc when the op updates them
                status_next[7:5] = alu_res[7:5];
                status_next[2:0] = alu_res[2:0];
            end
            status_next[csf_pkg::Z_BIT] = alu_z;
            if (c_upd)
                status_next[csf_pkg::C_BIT] = alu_c;
            if (digit_c_upd)
                status_next[csf_pkg::DIGIT_C_BIT] = alu_digit_c;
        end
        if (sleep_exec) begin
            status_next[csf_pkg::TIMEOUT_BIT]   = 1'b1;
            status_next[csf_pkg::POWERDOWN_BIT] = 1'b0;
        end
        if (clear_watchdog_instr) begin
            status_next[csf_pkg::TIMEOUT_BIT]   = 1'b1;
            status_next[csf_pkg::POWERDOWN_BIT] = 1'b1;
        end
        if (watchdog_timeout)
            status_next[csf_pkg::TIMEOUT_BIT] = 1'b0;
        if (master_clear_pin)
            // master clear keeps watchdog and powerdown flags
            status_next[7:5] = 3'b000;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            status_reg   <= csf_pkg::STATUS_POR;
            option_reg   <= csf_pkg::OPTION_POR;
            a_reg        <= 8'h00;
            b_reg        <= 8'h00;
            res_reg      <= 8'h00;
            op_reg       <= 3'h0;
            ist_reg      <= 5'h00;
            imask_reg    <= 5'h00;
            por_done_reg <= 1'b0;
        end else begin
            status_reg   <= status_next;
            por_done_reg <= 1'b1;
            if (wr_opt)
                option_reg <= writedata[7:0];
            if (wr_a)
                a_reg <= writedata[7:0];
            if (wr_b)
                b_reg <= writedata[7:0];
            if (wr_cmd) begin
                res_reg <= alu_res;
                op_reg  <= writedata[2:0];
            end
            if (wr_imk)
                imask_reg <= writedata[4:0];
            // set wins over write-one-to-clear
            ist_reg <= (ist_reg & ~(wr_ist ? writedata[4:0] : 5'h00))
                       | ev_vec;
        end
    end

    // one wait state per access, answer on the second edge
    always_ff @(posedge clock) begin
        if (srst) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            resp_reg  <= 2'b00;
        end else begin
            ack_reg  <= req;
            resp_reg <= (req && !mapped) ? 2'b11 : 2'b00;
            if (req && read)
                rdata_reg <= rd_mux(address);
        end
    end

    function automatic logic [31:0] rd_mux(input logic [7:0] adr);
        logic [7:0] v;
        v = 8'h00;
        if (adr == csf_pkg::STATUS_IDX || adr == csf_pkg::STATUS_ALIAS)
            v = status_reg;
        else if (adr == csf_pkg::OPTION_IDX)
            v = option_reg;
        else if (adr == csf_pkg::IRQ_STAT_IDX)
            v = {3'b000, ist_reg};
        else if (adr == csf_pkg::IRQ_MASK_IDX)
            v = {3'b000, imask_reg};
        else if (adr == csf_pkg::ALU_A_IDX)
            v = a_reg;
        else if (adr == csf_pkg::ALU_B_IDX)
            v = b_reg;
        else if (adr == csf_pkg::ALU_CMD_IDX)
            v = {5'b00000, op_reg};
        else if (adr == csf_pkg::ALU_RES_IDX)
            v = res_reg;
        else if (adr == csf_pkg::TMR_IDX)
            v = tmr_count;
        return {24'h000000, v};
    endfunction

    assign waitrequest = (read | write) & ~ack_reg;
    assign readdata    = rdata_reg;
    assign response    = resp_reg;
    // only the lower direct bank bit selects a 128-byte bank
    assign bank_sel    = status_reg[csf_pkg::BANK_LO_BIT];
    assign irq         = |(ist_reg & imask_reg);

    property p_timeout_clears;
        @(posedge clock) disable iff (srst)
        watchdog_timeout |=> !status_reg[csf_pkg::TIMEOUT_BIT];
    endproperty
    a_timeout_clears: assert property (p_timeout_clears)
        else $error("timeout did not clear watchdog flag");
    property p_clear_wdog_sets;
        @(posedge clock) disable iff (srst)
        clear_watchdog_instr && !watchdog_timeout
        |=> status_reg[csf_pkg::TIMEOUT_BIT]
            && status_reg[csf_pkg::POWERDOWN_BIT];
    endproperty
    a_clear_wdog_sets: assert property (p_clear_wdog_sets)
        else $error("clear watchdog did not set reset-cause flags");
    property p_sleep_to;
        @(posedge clock) disable iff (srst)
        sleep_exec && !watchdog_timeout
        |=> status_reg[csf_pkg::TIMEOUT_BIT];
    endproperty
    a_sleep_to: assert property (p_sleep_to)
        else $error("sleep did not set watchdog flag");
    property p_sleep_pd;
        @(posedge clock) disable iff (srst)
        sleep_exec && !clear_watchdog_instr
        |=> !status_reg[csf_pkg::POWERDOWN_BIT];
    endproperty
    a_sleep_pd: assert property (p_sleep_pd)
        else $error("sleep did not clear powerdown flag");
    property p_master_clear_pin_keep;
        @(posedge clock) disable iff (srst)
        master_clear_pin && !sleep_exec && !clear_watchdog_instr
        && !watchdog_timeout |=> status_reg[4:3] == $past(status_reg[4:3]);
    endproperty
    a_master_clear_pin_keep: assert property (p_master_clear_pin_keep)
        else $error("master clear changed reset-cause flags");
    property p_master_clear_pin_bank;
        @(posedge clock) disable iff (srst)
        master_clear_pin |=> status_reg[7:5] == 3'b000;
    endproperty
    a_master_clear_pin_bank: assert property (p_master_clear_pin_bank)
        else $error("master clear left bank select bits set");
    property p_zero;
        @(posedge clock) disable iff (srst)
        wr_cmd && !master_clear_pin
        |=> status_reg[csf_pkg::Z_BIT] == (res_reg == 8'h00);
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero flag wrong");
    property p_rrf;
        @(posedge clock) disable iff (srst)
        wr_cmd && writedata[2:0] == 3'b011
        |=> status_reg[csf_pkg::C_BIT] == $past(a_reg[0]);
    endproperty
    a_rrf: assert property (p_rrf)
        else $error("rotate right carry wrong");
    property p_rlf;
        @(posedge clock) disable iff (srst)
        wr_cmd && writedata[2:0] == 3'b100
        |=> status_reg[csf_pkg::C_BIT] == $past(a_reg[7]);
    endproperty
    a_rlf: assert property (p_rlf)
        else $error("rotate left carry wrong");
    property p_sub;
        @(posedge clock) disable iff (srst)
        wr_cmd && writedata[2:0] == 3'b001
        |=> status_reg[csf_pkg::C_BIT] == ($past(a_reg) >= $past(b_reg));
    endproperty
    a_sub: assert property (p_sub)
        else $error("subtract borrow wrong");
    property p_st_block;
        @(posedge clock) disable iff (srst)
        wr_cmd && writedata[3:0] == 4'h8
        |=> status_reg[csf_pkg::C_BIT]
            == (({1'b0, $past(a_reg)} + {1'b0, $past(b_reg)}) > 9'h0ff)
            && status_reg[csf_pkg::Z_BIT] == (res_reg == 8'h00);
    endproperty
    a_st_block: assert property (p_st_block)
        else $error("status destination wrote flag bits");
    property p_ack;
        @(posedge clock) disable iff (srst)
        (read | write) && waitrequest |=> !waitrequest;
    endproperty
    a_ack: assert property (p_ack)
        else $error("bus answer later than one wait state");
    property p_set_wins;
        @(posedge clock) disable iff (srst)
        ev_vec != 5'h00 |=> (ist_reg & $past(ev_vec)) == $past(ev_vec);
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost against status clear");
    c_st_dest: cover property (@(posedge clock) cmd_st);
    c_sleep: cover property (@(posedge clock) sleep_exec);
    c_timeout: cover property (@(posedge clock) watchdog_timeout);
    c_sub: cover property (@(posedge clock) wr_cmd && writedata[2:0] == 3'b001);
    c_irq: cover property (@(posedge clock) irq);
endmodule
